// *** common/tmcw_pkg.sv ***
// constants and types for the timer control-word decode block
package tmcw_pkg;

  localparam int unsigned TMCW_NCNT = 3;

  // host i/o offsets: three counter locations and the shared control word
  localparam logic [3:0] TMCW_OFS_CNT0 = 4'hc;
  localparam logic [3:0] TMCW_OFS_CNT1 = 4'hd;
  localparam logic [3:0] TMCW_OFS_CNT2 = 4'he;
  localparam logic [3:0] TMCW_OFS_CTRL = 4'hf;

  // control word fields
  localparam int unsigned TMCW_BCD_BIT  = 0;
  localparam int unsigned TMCW_MODE_LSB = 1;
  localparam int unsigned TMCW_ACC_LSB  = 4;
  localparam int unsigned TMCW_SEL_LSB  = 6;
  localparam int unsigned TMCW_CTL_W    = 6;

  // readback command fields
  localparam int unsigned TMCW_PICK_LSB  = 1;
  localparam int unsigned TMCW_STA_N_BIT = 4;
  localparam int unsigned TMCW_CNT_N_BIT = 5;

  // byte access codes and the readback select code
  localparam logic [1:0] TMCW_ACC_LATCH = 2'h0;
  localparam logic [1:0] TMCW_ACC_LO    = 2'h1;
  localparam logic [1:0] TMCW_ACC_HI    = 2'h2;
  localparam logic [1:0] TMCW_ACC_LOHI  = 2'h3;
  localparam logic [1:0] TMCW_SEL_RB    = 2'h3;

  localparam logic [15:0] TMCW_ONE  = 16'h0001;
  localparam logic [15:0] TMCW_TWO  = 16'h0002;
  localparam logic [3:0]  TMCW_DECADE = 4'ha;
  localparam logic [7:0]  TMCW_RD_IDLE = 8'h00;

  typedef enum logic [2:0] {
    TMCW_FUNC_TC      = 3'b000,
    TMCW_FUNC_ONESHOT = 3'b001,
    TMCW_FUNC_RATE    = 3'b010,
    TMCW_FUNC_SQUARE  = 3'b011,
    TMCW_FUNC_SWSTB   = 3'b100,
    TMCW_FUNC_HWSTB   = 3'b101
  } tmcw_func_t;

  // top bit ignored for the rate and square codes
  function automatic tmcw_func_t tmcw_decode(input logic [2:0] m);
    case (m[1:0])
      2'b10:   tmcw_decode = TMCW_FUNC_RATE;
      2'b11:   tmcw_decode = TMCW_FUNC_SQUARE;
      default: tmcw_decode = tmcw_func_t'(m);
    endcase
  endfunction

endpackage

// *** verilog/tmcw_sync.sv ***
// two-flop synchroniser with rising-edge detect for one pin
`timescale 1ns/1ps
`default_nettype none
module tmcw_sync
  import tmcw_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_nrst,
  input  wire logic i_ce,
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_rise
);
  logic [2:0] sh_q;
  logic [2:0] sh_d;

  // edge taken from the second and third stages only
  always_comb begin
    sh_d = {sh_q[1:0], i_pin};
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sh_q <= 3'h0;
    end else if (i_ce) begin
      sh_q <= sh_d;
    end
  end

  assign o_level = sh_q[1];
  assign o_rise  = sh_q[1] & ~sh_q[2];
endmodule // tmcw_sync
`default_nettype wire

// *** verilog/tmcw_dec.sv ***
// binary or four-decade decrement by one or two
`timescale 1ns/1ps
`default_nettype none
module tmcw_dec
  import tmcw_pkg::*;
(
  input  wire logic [15:0] i_val,
  input  wire logic        i_bcd,
  input  wire logic        i_two,
  output logic      [15:0] o_val
);
  logic [3:0]  step;
  logic [4:0]  bw;
  logic [15:0] bcd_val;

  assign step  = i_two ? TMCW_TWO[3:0] : TMCW_ONE[3:0];
  assign bw[0] = 1'b0;

  for (genvar g = 0; g < 4; g++) begin : g_dig
    logic [3:0] dg;
    logic [3:0] sub;
    assign dg  = i_val[4*g +: 4];
    assign sub = (g == 0) ? step : {3'h0, bw[g]};
    assign bw[g+1] = dg < sub;
    assign bcd_val[4*g +: 4] = bw[g+1] ? 4'(dg + TMCW_DECADE - sub)
                                       : 4'(dg - sub);
  end

  assign o_val = i_bcd ? bcd_val : 16'(i_val - {12'h000, step});
endmodule // tmcw_dec
`default_nettype wire

// *** verilog/tmcw_top.sv ***
// three down-counters with control-word decode, latch and readback
// Behaviour
// - radix bit 0 counts binary to 65535, 1 counts four decades to 9999
// - function field: 0 tc, 1 one-shot, x10 rate, x11 square, 4/5 strobes
// - access field 00 latch, 01 low byte, 10 high byte, 11 low then high
// - low-then-high accesses alternate bytes, tracked by a byte-order flop
// - access 00 copies live count into hold register, counting undisturbed
// - read returns held value after a latch, otherwise the live count
// - select field 00/01/10 picks counter 0/1/2, 11 means readback
// - readback has three independent one-hot counter selects
// - readback count-latch bit 0 latches all selected counters together
// - readback status bit 0 makes next read return the status byte
// - status bits 0-5 control fields, bit 6 load pending, bit 7 output
// - load-pending flag set until new count moves into counting element
// - status output bit is the output level when status is captured
// - rate mode: output low one period per N; gate low forces high, reload
// - square mode odd N: high (N+1)/2, low (N-1)/2; even N symmetrical
// - one-shot/hw strobe: gate rise starts or restarts; new count next cycle
`timescale 1ns/1ps
`default_nettype none
module tmcw_top
  import tmcw_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_nrst,
  input  wire logic       i_ce,
  input  wire logic [3:0] i_addr,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  input  wire logic [2:0] i_cnt_clk,
  input  wire logic [2:0] i_gate,
  output logic      [2:0] o_out
);
  logic [7:0] rd_byte [TMCW_NCNT];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       ctl_wr;
  logic [1:0] ctl_sel;
  logic [1:0] ctl_acc;

  assign ctl_wr  = i_wr & (i_addr == TMCW_OFS_CTRL);
  assign ctl_sel = i_wdata[TMCW_SEL_LSB +: 2];
  assign ctl_acc = i_wdata[TMCW_ACC_LSB +: 2];

  for (genvar k = 0; k < TMCW_NCNT; k++) begin : g_cnt
    localparam logic [3:0] OFS = 4'(TMCW_OFS_CNT0 + 4'(k));
    localparam logic [1:0] KID = 2'(k);

    logic [5:0]  ctl_q, ctl_d;
    logic        flip_q, flip_d;
    logic [7:0]  crl_q, crl_d;
    logic [15:0] cr_q, cr_d;
    logic [15:0] hold_q, hold_d;
    logic        held_q, held_d;
    logic [7:0]  stat_q, stat_d;
    logic        statv_q, statv_d;
    logic [15:0] cnt_q, cnt_d;
    logic        out_q, out_d;
    logic        null_q, null_d;
    logic        ldreq_q, ldreq_d;
    logic        trig_q, trig_d;
    logic        run_q, run_d;

    logic        tick, gate, gate_rise;
    logic        wr_me, rd_me, mode_wr, rb_me, latch_me, stat_me;
    logic        load, bcd;
    logic [1:0]  acc;
    tmcw_func_t  func;
    tmcw_func_t  new_func;
    logic [15:0] dec1, dec2, cr_m1, src;

    tmcw_sync u_ck (
      .i_clock (i_clock),
      .i_nrst  (i_nrst),
      .i_ce    (i_ce),
      .i_pin   (i_cnt_clk[k]),
      .o_level (),
      .o_rise  (tick)
    );

    tmcw_sync u_gt (
      .i_clock (i_clock),
      .i_nrst  (i_nrst),
      .i_ce    (i_ce),
      .i_pin   (i_gate[k]),
      .o_level (gate),
      .o_rise  (gate_rise)
    );

    tmcw_dec u_d1 (
      .i_val (cnt_q),
      .i_bcd (bcd),
      .i_two (1'b0),
      .o_val (dec1)
    );

    tmcw_dec u_d2 (
      .i_val (cnt_q),
      .i_bcd (bcd),
      .i_two (1'b1),
      .o_val (dec2)
    );

    tmcw_dec u_dr (
      .i_val (cr_q),
      .i_bcd (bcd),
      .i_two (1'b0),
      .o_val (cr_m1)
    );

    assign bcd      = ctl_q[TMCW_BCD_BIT];
    assign func     = tmcw_decode(ctl_q[TMCW_MODE_LSB +: 3]);
    assign new_func = tmcw_decode(i_wdata[TMCW_MODE_LSB +: 3]);
    assign acc      = ctl_q[TMCW_ACC_LSB +: 2];
    assign wr_me    = i_wr & (i_addr == OFS);
    assign rd_me    = i_rd & (i_addr == OFS);
    assign mode_wr  = ctl_wr & (ctl_sel == KID)
                    & (ctl_acc != TMCW_ACC_LATCH);
    assign rb_me    = ctl_wr & (ctl_sel == TMCW_SEL_RB)
                    & i_wdata[TMCW_PICK_LSB + k];
    assign latch_me = (ctl_wr & (ctl_sel == KID)
                      & (ctl_acc == TMCW_ACC_LATCH))
                    | (rb_me & ~i_wdata[TMCW_CNT_N_BIT]);
    assign stat_me  = rb_me & ~i_wdata[TMCW_STA_N_BIT];
    assign src      = held_q ? hold_q : cnt_q;

    always_comb begin
      ctl_d   = ctl_q;
      flip_d  = flip_q;
      crl_d   = crl_q;
      cr_d    = cr_q;
      hold_d  = hold_q;
      held_d  = held_q;
      stat_d  = stat_q;
      statv_d = statv_q;
      cnt_d   = cnt_q;
      out_d   = out_q;
      null_d  = null_q;
      ldreq_d = ldreq_q;
      trig_d  = trig_q;
      run_d   = run_q;
      load    = 1'b0;

      // count loads through the byte access mode
      if (wr_me) begin
        case (acc)
          TMCW_ACC_LO: begin
            cr_d = {8'h00, i_wdata};
            load = 1'b1;
          end
          TMCW_ACC_HI: begin
            cr_d = {i_wdata, 8'h00};
            load = 1'b1;
          end
          TMCW_ACC_LOHI: begin
            flip_d = ~flip_q;
            if (!flip_q) begin
              crl_d = i_wdata;
            end else begin
              cr_d = {i_wdata, crl_q};
              load = 1'b1;
            end
          end
          default: begin
            load = 1'b0;
          end
        endcase
      end
      if (rd_me) begin
        if (statv_q) begin
          statv_d = 1'b0;
        end else if (acc == TMCW_ACC_LOHI) begin
          flip_d = ~flip_q;
          if (flip_q) begin
            held_d = 1'b0;
          end
        end else begin
          held_d = 1'b0;
        end
      end

      // a second latch before the held value is read is ignored
      if (latch_me && !held_q) begin
        hold_d = cnt_q;
        held_d = 1'b1;
      end
      if (stat_me && !statv_q) begin
        stat_d  = {out_q, null_q, ctl_q};
        statv_d = 1'b1;
      end

      // gate low in periodic modes forces output high and a reload
      if (((func == TMCW_FUNC_RATE) || (func == TMCW_FUNC_SQUARE))
          && !gate) begin
        out_d = 1'b1;
        if (run_q) begin
          ldreq_d = 1'b1;
          run_d   = 1'b0;
        end
      end

      if (tick) begin
        case (func)
          TMCW_FUNC_TC: begin
            if (ldreq_q) begin
              cnt_d   = cr_q;
              null_d  = 1'b0;
              ldreq_d = 1'b0;
              run_d   = 1'b1;
            end else if (gate && run_q) begin
              cnt_d = dec1;
              if (cnt_q == TMCW_ONE) begin
                out_d = 1'b1;
              end
            end
          end
          TMCW_FUNC_ONESHOT, TMCW_FUNC_HWSTB: begin
            if (func == TMCW_FUNC_HWSTB) begin
              out_d = 1'b1;
            end
            if (trig_q) begin
              cnt_d  = cr_q;
              null_d = 1'b0;
              trig_d = 1'b0;
              run_d  = 1'b1;
              if (func == TMCW_FUNC_ONESHOT) begin
                out_d = 1'b0;
              end
            end else if (run_q) begin
              cnt_d = dec1;
              if (cnt_q == TMCW_ONE) begin
                run_d = 1'b0;
                out_d = (func == TMCW_FUNC_ONESHOT);
              end
            end
          end
          TMCW_FUNC_RATE: begin
            if (gate && ldreq_q) begin
              cnt_d   = cr_q;
              null_d  = 1'b0;
              ldreq_d = 1'b0;
              run_d   = 1'b1;
              out_d   = 1'b1;
            end else if (gate && run_q) begin
              out_d = 1'b1;
              if (cnt_q == TMCW_ONE) begin
                cnt_d  = cr_q;
                null_d = 1'b0;
              end else begin
                cnt_d = dec1;
                if (cnt_q == TMCW_TWO) begin
                  out_d = 1'b0;
                end
              end
            end
          end
          TMCW_FUNC_SQUARE: begin
            if (gate && ldreq_q) begin
              cnt_d   = cr_q;
              null_d  = 1'b0;
              ldreq_d = 1'b0;
              run_d   = 1'b1;
              out_d   = 1'b1;
            end else if (gate && run_q) begin
              if (cnt_q <= TMCW_TWO) begin
                out_d  = ~out_q;
                null_d = 1'b0;
                // odd count: low half one count shorter
                cnt_d  = (out_q && cr_q[0]) ? cr_m1 : cr_q;
              end else begin
                cnt_d = dec2;
              end
            end
          end
          TMCW_FUNC_SWSTB: begin
            out_d = 1'b1;
            if (ldreq_q) begin
              cnt_d   = cr_q;
              null_d  = 1'b0;
              ldreq_d = 1'b0;
              run_d   = 1'b1;
            end else if (gate && run_q) begin
              cnt_d = dec1;
              if (cnt_q == TMCW_ONE) begin
                out_d = 1'b0;
                run_d = 1'b0;
              end
            end
          end
          default: begin
            cnt_d = cnt_q;
          end
        endcase
      end

      // after the tick so a load in a tick cycle stays pending
      if (load) begin
        null_d = 1'b1;
        if (func == TMCW_FUNC_TC) begin
          out_d = 1'b0;
        end
        // periodic modes pick a new count up at their terminal count
        if ((func != TMCW_FUNC_ONESHOT) && (func != TMCW_FUNC_HWSTB)
            && !(((func == TMCW_FUNC_RATE) || (func == TMCW_FUNC_SQUARE))
                 && run_q)) begin
          ldreq_d = 1'b1;
        end
      end

      // a trigger in the cycle that consumes the last one is kept
      if (gate_rise && ((func == TMCW_FUNC_ONESHOT)
                        || (func == TMCW_FUNC_HWSTB))) begin
        trig_d = 1'b1;
      end

      if (mode_wr) begin
        ctl_d   = i_wdata[TMCW_CTL_W-1:0];
        flip_d  = 1'b0;
        held_d  = 1'b0;
        statv_d = 1'b0;
        null_d  = 1'b1;
        ldreq_d = 1'b0;
        trig_d  = 1'b0;
        run_d   = 1'b0;
        out_d   = (new_func != TMCW_FUNC_TC);
      end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
        ctl_q   <= 6'h00;
        flip_q  <= 1'b0;
        crl_q   <= 8'h00;
        cr_q    <= 16'h0000;
        hold_q  <= 16'h0000;
        held_q  <= 1'b0;
        stat_q  <= 8'h00;
        statv_q <= 1'b0;
        cnt_q   <= 16'h0000;
        out_q   <= 1'b0;
        null_q  <= 1'b0;
        ldreq_q <= 1'b0;
        trig_q  <= 1'b0;
        run_q   <= 1'b0;
      end else if (i_ce) begin
        ctl_q   <= ctl_d;
        flip_q  <= flip_d;
        crl_q   <= crl_d;
        cr_q    <= cr_d;
        hold_q  <= hold_d;
        held_q  <= held_d;
        stat_q  <= stat_d;
        statv_q <= statv_d;
        cnt_q   <= cnt_d;
        out_q   <= out_d;
        null_q  <= null_d;
        ldreq_q <= ldreq_d;
        trig_q  <= trig_d;
        run_q   <= run_d;
      end
    end

    // status first, then the byte the access mode points at
    assign rd_byte[k] = statv_q ? stat_q
                      : (acc == TMCW_ACC_HI) ? src[15:8]
                      : (acc == TMCW_ACC_LO) ? src[7:0]
                      : flip_q ? src[15:8] : src[7:0];
    assign o_out[k] = out_q;
  end

  always_comb begin
    rdata_d = rdata_q;
    if (i_rd) begin
      case (i_addr)
        TMCW_OFS_CNT0: rdata_d = rd_byte[0];
        TMCW_OFS_CNT1: rdata_d = rd_byte[1];
        TMCW_OFS_CNT2: rdata_d = rd_byte[2];
        default:       rdata_d = TMCW_RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= 8'h00;
    end else if (i_ce) begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;
endmodule // tmcw_top
`default_nettype wire

// *** testbench/tmcw_top_assertions.sv ***
// port-level checks for the timer control-word decode block
`timescale 1ns/1ps
`default_nettype none
module tmcw_top_check
  import tmcw_pkg::*;
(
  input wire logic       i_clock,
  input wire logic       i_nrst,
  input wire logic       i_ce,
  input wire logic [3:0] i_addr,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic [2:0] i_cnt_clk,
  input wire logic [2:0] i_gate,
  input wire logic [2:0] o_out
);
  logic       ctl_wr;
  logic [2:0] quiet_q;
  logic [2:0] quiet_d;
  logic [1:0] pin_q;

  default clocking @(posedge i_clock); endclocking

  assign ctl_wr = i_ce && i_wr && i_addr == TMCW_OFS_CTRL
                  && i_wdata[5:4] != TMCW_ACC_LATCH;

  // cycles since counter 0 last saw a pin change or a write; saturates
  always_comb begin
    quiet_d = (quiet_q == 3'h7) ? quiet_q : quiet_q + 3'h1;
    if ({i_cnt_clk[0], i_gate[0]} != pin_q || (i_ce && i_wr)) begin
      quiet_d = 3'h0;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      quiet_q <= 3'h0;
      pin_q   <= 2'h0;
    end else begin
      quiet_q <= quiet_d;
      pin_q   <= {i_cnt_clk[0], i_gate[0]};
    end
  end

  a_reset_rdata_zero: assert property (
    !i_nrst |-> o_rdata == 8'h00)
    else $error("read data not zero in reset");
  a_reset_out_low: assert property (
    !i_nrst |-> o_out == 3'h0)
    else $error("outputs not low in reset");
  a_rdata_holds: assert property (
    disable iff (!i_nrst) !(i_ce && i_rd) |=> $stable(o_rdata))
    else $error("read data moved without a read");
  a_unmapped_read: assert property (
    disable iff (!i_nrst)
    i_ce && i_rd && i_addr < TMCW_OFS_CNT0 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_mode_out_zero: assert property (
    disable iff (!i_nrst) ctl_wr && i_wdata[7:6] == 2'h0
    |=> o_out[0] == ($past(i_wdata[3:1]) != 3'h0))
    else $error("counter 0 output level wrong after mode word");
  a_mode_out_one: assert property (
    disable iff (!i_nrst) ctl_wr && i_wdata[7:6] == 2'h1
    |=> o_out[1] == ($past(i_wdata[3:1]) != 3'h0))
    else $error("counter 1 output level wrong after mode word");
  a_mode_out_two: assert property (
    disable iff (!i_nrst) ctl_wr && i_wdata[7:6] == 2'h2
    |=> o_out[2] == ($past(i_wdata[3:1]) != 3'h0))
    else $error("counter 2 output level wrong after mode word");
  a_out_has_cause: assert property (
    disable iff (!i_nrst) $changed(o_out[0]) |-> quiet_q < 3'h7)
    else $error("counter 0 output moved with no pin or write");

  c_status_req: cover property (ctl_wr && i_wdata == 8'he2);
  c_latch_cmd: cover property (i_ce && i_wr && i_addr == TMCW_OFS_CTRL
                               && i_wdata == 8'h00);
  c_group_latch: cover property (ctl_wr && i_wdata == 8'hdc);
endmodule // tmcw_top_check

bind tmcw_top tmcw_top_check tmcw_top_check_i (
  .i_clock(i_clock), .i_nrst(i_nrst), .i_ce(i_ce), .i_addr(i_addr),
  .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
  .i_cnt_clk(i_cnt_clk), .i_gate(i_gate), .o_out(o_out));
`default_nettype wire

// *** testbench/tmcw_host.sv ***
// host processor model issuing single-byte i/o cycles
`timescale 1ns/1ps
`default_nettype none
module tmcw_host (
  input  wire logic       i_clock,
  input  wire logic [7:0] i_rdata,
  output logic      [3:0] o_addr,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_wdata
);
  initial begin
    o_addr  = 4'h0;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_wdata = 8'h00;
  end

  // released lines show the inverse so a stale value never looks valid
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    o_wr    <= 1'b1;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_clock);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask

  task automatic get(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clock);
    o_rd   <= 1'b1;
    o_addr <= a;
    @(posedge i_clock);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    @(negedge i_clock);
    d = i_rdata;
  endtask
endmodule // tmcw_host
`default_nettype wire

// *** testbench/tmcw_top_test.sv ***
// self-checking bench for the timer control-word decode block
`timescale 1ns/1ps
`default_nettype none
module tmcw_top_test
  import tmcw_pkg::*;
;
  logic       i_clock;
  logic       i_nrst;
  logic       i_ce;
  logic [3:0] i_addr;
  logic       i_wr;
  logic       i_rd;
  logic [7:0] i_wdata;
  logic [7:0] o_rdata;
  logic [2:0] i_cnt_clk;
  logic [2:0] i_gate;
  logic [2:0] o_out;
  logic [7:0] got;
  int         error_cnt;
  int         n_checks;

  // square wave N = 5, output after each tick: high three, low two
  localparam logic [4:0] SQ_WAVE = 5'h13;

  tmcw_top tmcw_top_i (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_ce(i_ce), .i_addr(i_addr),
    .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .i_cnt_clk(i_cnt_clk), .i_gate(i_gate), .o_out(o_out));

  tmcw_host tmcw_host_i (
    .i_clock(i_clock), .i_rdata(o_rdata), .o_addr(i_addr),
    .o_wr(i_wr), .o_rd(i_rd), .o_wdata(i_wdata));

  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  task automatic conclude;
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_out(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t output %b expected %b", $time, g, e);
    end
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    tmcw_host_i.get(a, got);
    chk8(got, e);
  endtask

  // slow enough for the two-flop pin synchroniser to see both edges
  task automatic tick(input int k);
    @(posedge i_clock);
    i_cnt_clk[k] <= 1'b1;
    repeat (4) @(posedge i_clock);
    i_cnt_clk[k] <= 1'b0;
    repeat (6) @(posedge i_clock);
  endtask

  // gate level settles through the synchroniser before returning
  task automatic set_gate(input int k, input logic v);
    @(posedge i_clock);
    i_gate[k] <= v;
    repeat (5) @(posedge i_clock);
  endtask

  initial begin
    #200us;
    error_cnt++;
    conclude();
  end

  initial begin
    i_nrst    = 1'b0;
    i_ce      = 1'b1;
    i_cnt_clk = 3'h0;
    i_gate    = 3'h7;
    repeat (5) @(posedge i_clock);
    i_nrst <= 1'b1;
    rd_chk(4'h3, 8'h00);
    tmcw_host_i.put(4'hf, 8'h34);
    tmcw_host_i.put(4'hc, 8'h11);
    tmcw_host_i.put(4'hf, 8'h34);
    tmcw_host_i.put(4'hc, 8'h64);
    tmcw_host_i.put(4'hc, 8'h00);
    tmcw_host_i.put(4'hf, 8'he2);
    rd_chk(4'hc, 8'hf4);
    tick(0);
    tmcw_host_i.put(4'hf, 8'he2);
    rd_chk(4'hc, 8'hb4);
    tmcw_host_i.put(4'hf, 8'h00);
    rd_chk(4'hc, 8'h64);
    rd_chk(4'hc, 8'h00);
    rd_chk(4'hc, 8'h64);
    rd_chk(4'hc, 8'h00);
    tmcw_host_i.put(4'hf, 8'hc2);
    rd_chk(4'hc, 8'hb4);
    rd_chk(4'hc, 8'h64);
    rd_chk(4'hc, 8'h00);
    tmcw_host_i.put(4'hf, 8'h75);
    tmcw_host_i.put(4'hd, 8'h00);
    tmcw_host_i.put(4'hd, 8'h10);
    tmcw_host_i.put(4'hf, 8'hb4);
    tmcw_host_i.put(4'he, 8'h00);
    tmcw_host_i.put(4'he, 8'h10);
    repeat (2) begin
      tick(1);
      tick(2);
    end
    tmcw_host_i.put(4'hf, 8'hdc);
    tick(1);
    tick(2);
    rd_chk(4'hd, 8'h99);
    rd_chk(4'hd, 8'h09);
    rd_chk(4'he, 8'hff);
    rd_chk(4'he, 8'h0f);
    tmcw_host_i.put(4'hf, 8'h14);
    tmcw_host_i.put(4'hc, 8'h05);
    tick(0);
    tmcw_host_i.put(4'hf, 8'h00);
    rd_chk(4'hc, 8'h05);
    tmcw_host_i.put(4'hf, 8'h24);
    tmcw_host_i.put(4'hc, 8'h03);
    tick(0);
    tmcw_host_i.put(4'hf, 8'h00);
    rd_chk(4'hc, 8'h03);
    // rate, N = 5: a gate pulse mid-count forces a reload
    tmcw_host_i.put(4'hf, 8'h14);
    tmcw_host_i.put(4'hc, 8'h05);
    repeat (2) tick(0);
    set_gate(0, 1'b0);
    set_gate(0, 1'b1);
    repeat (3) tick(0);
    chk_out(o_out[0], 1'b1);
    repeat (2) tick(0);
    chk_out(o_out[0], 1'b0);
    set_gate(0, 1'b0);
    chk_out(o_out[0], 1'b1);
    set_gate(0, 1'b1);
    // square, N = 5, odd count
    tmcw_host_i.put(4'hf, 8'h16);
    tmcw_host_i.put(4'hc, 8'h05);
    tick(0);
    for (int i = 0; i < 5; i++) begin
      tick(0);
      chk_out(o_out[0], SQ_WAVE[i]);
    end
    // one-shot, N = 3: a second gate rise restarts the cycle
    tmcw_host_i.put(4'hf, 8'h12);
    tmcw_host_i.put(4'hc, 8'h03);
    set_gate(0, 1'b0);
    set_gate(0, 1'b1);
    tick(0);
    chk_out(o_out[0], 1'b0);
    repeat (2) tick(0);
    set_gate(0, 1'b0);
    set_gate(0, 1'b1);
    tick(0);
    chk_out(o_out[0], 1'b0);
    repeat (3) tick(0);
    chk_out(o_out[0], 1'b1);
    for (int m = 0; m < 8; m++) begin
      tmcw_host_i.put(4'hf, {2'h2, TMCW_ACC_LOHI, m[2:0], 1'b0});
      tmcw_host_i.put(4'hf, 8'he8);
      tmcw_host_i.get(4'he, got);
      chk8({1'b0, got[7], got[5:0]},
           {1'b0, (m != 0), TMCW_ACC_LOHI, m[2:0], 1'b0});
    end
    conclude();
  end
endmodule // tmcw_top_test
`default_nettype wire
